// >>> rtl/asc_defines.svh
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH
// ==========================================================
// timing of the sram pin sequence, clock at 10 MHz
`define ASC_CLK_PERIOD_NS   100
`define ASC_ADDR_W          20
`define ASC_DATA_W          16
// write strobe low time: float delay plus data setup, in ns
`define ASC_FLOAT_DELAY_NS  8
`define ASC_DATA_SETUP_NS   8
`define ASC_STROBE_NS       (`ASC_FLOAT_DELAY_NS + `ASC_DATA_SETUP_NS)
// least time rounds up, plus one spare cycle
`define ASC_STROBE_CYC      (((`ASC_STROBE_NS + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS) + 1)
// read access time, in ns and in cycles
`define ASC_ACCESS_NS       15
`define ASC_ACCESS_CYC      (((`ASC_ACCESS_NS + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS) + 1)
`define ASC_CNT_W           4
`endif

// >>> rtl/asc_pkg.sv
// ==========================================================
// types shared by the controller modules
package asc_pkg;
   // one-hot states of the access sequencer
   typedef enum logic [4:0] {
      ASC_IDLE   = 5'h01,
      ASC_RSETUP = 5'h02,
      ASC_RWAIT  = 5'h04,
      ASC_WLOW   = 5'h08,
      ASC_WEND   = 5'h10
   } asc_state_t;
endpackage

// >>> rtl/asc_pins_if.sv
`timescale 1ns/100ps
// ==========================================================
// sram pin bundle between sequencer and pin driver
interface asc_pins_if;
   logic        select_en;   // select the memory
   logic        read_en;     // output enable active
   logic        write_en;    // write strobe active
   logic [1:0]  lanes;       // byte lanes in use, bit0 low lane
   logic        drive_en;    // host drives data lanes
   modport seq (output select_en, output read_en, output write_en, output lanes,
                output drive_en);
   modport drv (input select_en, input read_en, input write_en, input lanes,
                input drive_en);
endinterface

// >>> rtl/asc_pin_drv.sv
`timescale 1ns/100ps
`include "asc_defines.svh"
// ==========================================================
// pin driver: turns sequencer levels into pin levels, active low except second select and data enable
module asc_pin_drv (
   input  wire logic    clk_in,
   input  wire logic    rst_n_in,
   asc_pins_if.drv      pins,
   output logic         first_select_n_out,
   output logic         second_select_out,
   output logic         output_enable_n_out,
   output logic         write_strobe_n_out,
   output logic         low_byte_sel_n_out,
   output logic         high_byte_sel_n_out,
   output logic         data_oe_out
);
   // ==========================================================
   // registered pins, all idle / deselected at reset: high except second select and data enable, which reset low
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         first_select_n_out  <= 1'b1;
         second_select_out   <= 1'b0;
         output_enable_n_out <= 1'b1;
         write_strobe_n_out  <= 1'b1;
         low_byte_sel_n_out  <= 1'b1;
         high_byte_sel_n_out <= 1'b1;
         data_oe_out         <= 1'b0;
      end else begin
         first_select_n_out  <= ~pins.select_en;
         second_select_out   <= pins.select_en;
         output_enable_n_out <= ~pins.read_en;
         write_strobe_n_out  <= ~pins.write_en;
         low_byte_sel_n_out  <= ~pins.lanes[0];
         high_byte_sel_n_out <= ~pins.lanes[1];
         data_oe_out         <= pins.drive_en;
      end
   end
endmodule // asc_pin_drv

// >>> rtl/asc_ctrl.sv
`timescale 1ns/100ps
`include "asc_defines.svh"
// ==========================================================
// Overview of operation
// - data held across the edge ending write
// - host never drives while memory drives lanes
// - write strobe high for every read
// - address valid before select falls
// - strobe at least float delay plus setup
// ==========================================================
module asc_ctrl #(
   parameter int ADDR_W = `ASC_ADDR_W,
   parameter int DATA_W = `ASC_DATA_W
) (
   input  wire logic              clock_in,
   input  wire logic              resetn_in,
   input  wire logic              req_in,          // start access, level sampled in idle
   input  wire logic              req_write_in,    // 1 write, 0 read
   input  wire logic [1:0]        req_lanes_in,    // byte lanes, bit0 low
   input  wire logic [ADDR_W-1:0] req_addr_in,
   input  wire logic [DATA_W-1:0] req_wdata_in,
   input  wire logic [DATA_W-1:0] mem_data_in,     // data lanes as seen at pins
   input  wire logic              ecc_fix_flag_in, // memory corrected-error flag
   output logic                   busy_out,
   output logic                   done_out,        // high for one cycle at completion
   output logic [DATA_W-1:0]      rdata_out,
   output logic                   rfix_out,        // read was corrected
   output logic [ADDR_W-1:0]      mem_addr_out,
   output logic [DATA_W-1:0]      mem_data_out,
   output logic                   mem_data_oe_out,
   output logic                   first_select_n_out,
   output logic                   second_select_out,
   output logic                   output_enable_n_out,
   output logic                   write_strobe_n_out,
   output logic                   low_byte_sel_n_out,
   output logic                   high_byte_sel_n_out
);
   // ==========================================================
   // reset release through two flip-flops
   // assertion is immediate; release waits two clock edges so that
   // no flip-flop below leaves reset on a partial clock
   logic rst_meta_q;  // first stage
   logic rst_n_q;     // synchronous copy used below
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   asc_pins_if pins ();
   asc_pkg::asc_state_t state_q;               // sequencer state
   logic [`ASC_CNT_W-1:0] cnt_q;               // cycle counter
   logic                  write_q;             // latched direction
   logic [1:0]            lanes_q;             // latched lanes

   // lane mask function, used for read merge
   function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] ln);
      lane_mask = {{(DATA_W/2){ln[1]}}, {(DATA_W/2){ln[0]}}};
   endfunction

   // a request is taken only with at least one lane; zero lanes
   // would neither read nor write, so such a request is dropped
   function automatic logic take_ok(input logic req, input logic [1:0] ln);
      take_ok = req && (ln != 2'h0);
   endfunction

   // last cycle of the read access wait, where data is captured
   function automatic logic read_end(input asc_pkg::asc_state_t st,
                                     input logic [`ASC_CNT_W-1:0] cnt);
      read_end = (st == asc_pkg::ASC_RWAIT) && (cnt == `ASC_CNT_W'(`ASC_ACCESS_CYC));
   endfunction

   // ==========================================================
   // sequencer: read = setup, wait access; write = setup, strobe low, end
   // read:  idle -> setup -> access wait for ACCESS_CYC+1 cycles
   // write: idle -> setup -> strobe low for STROBE_CYC+1 cycles -> end
   // the setup cycle puts the address on the pins two cycles ahead of
   // the select; the end cycle keeps select, lanes and data after the
   // strobe has risen, so the strobe edge always ends the write
   // pins follow the state one register later, in the pin driver
   // a request arriving while busy is not taken; it must be held
   always_ff @(posedge clock_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q <= asc_pkg::ASC_IDLE;
         cnt_q   <= '0;
         write_q <= 1'b0;
         lanes_q <= 2'h0;
      end else begin
         case (state_q)
            asc_pkg::ASC_IDLE: begin
               // idle: wait for a request that has lanes
               // zero lanes would write nothing; ignore such request
               if (take_ok(req_in, req_lanes_in)) begin
                  write_q <= req_write_in;
                  lanes_q <= req_lanes_in;
                  cnt_q   <= '0;
                  // address settles two cycles before select falls
                  state_q <= asc_pkg::ASC_RSETUP;
               end
            end
            asc_pkg::ASC_RSETUP: begin
               // one cycle of address setup before the select
               cnt_q   <= '0;
               state_q <= write_q ? asc_pkg::ASC_WLOW : asc_pkg::ASC_RWAIT;
            end
            asc_pkg::ASC_RWAIT: begin
               // access wait, counted up to the capture cycle
               if (read_end(state_q, cnt_q)) begin
                  state_q <= asc_pkg::ASC_IDLE;
               end else begin
                  cnt_q <= cnt_q + `ASC_CNT_W'(1);
               end
            end
            asc_pkg::ASC_WLOW: begin
               // strobe held long enough for float plus setup
               if (cnt_q == `ASC_CNT_W'(`ASC_STROBE_CYC)) begin
                  state_q <= asc_pkg::ASC_WEND;
               end else begin
                  cnt_q <= cnt_q + `ASC_CNT_W'(1);
               end
            end
            asc_pkg::ASC_WEND: begin
               // strobe already high; select, lanes and data held
               state_q <= asc_pkg::ASC_IDLE;
            end
            default: begin
               // unused code: back to idle
               state_q <= asc_pkg::ASC_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // pin levels from state
   // every level is a plain decode of the state (lanes also of lanes_q), so the pin driver
   // registers all of them on one edge with no skew between them
   always_comb begin
      pins.select_en = (state_q == asc_pkg::ASC_WLOW) ||
                       (state_q == asc_pkg::ASC_RWAIT) ||
                       (state_q == asc_pkg::ASC_WEND);
      // output enable off during writes, so memory never drives then
      pins.read_en   = (state_q == asc_pkg::ASC_RWAIT);
      // strobe low only in its own state; it rises before select and data
      pins.write_en  = (state_q == asc_pkg::ASC_WLOW);
      pins.lanes     = pins.select_en ? lanes_q : 2'h0;
      // data driven while strobe low and one cycle after strobe rises
      pins.drive_en  = (state_q == asc_pkg::ASC_WLOW) ||
                       (state_q == asc_pkg::ASC_WEND);
   end

   // pin driver: registers every pin level, idle levels in reset
   asc_pin_drv u_drv (
      .clk_in              (clock_in),
      .rst_n_in            (rst_n_q),
      .pins                (pins),
      .first_select_n_out  (first_select_n_out),
      .second_select_out   (second_select_out),
      .output_enable_n_out (output_enable_n_out),
      .write_strobe_n_out  (write_strobe_n_out),
      .low_byte_sel_n_out  (low_byte_sel_n_out),
      .high_byte_sel_n_out (high_byte_sel_n_out),
      .data_oe_out         (mem_data_oe_out)
   );

   // ==========================================================
   // address and write data, latched at request
   // both stay put until the next accepted request, which keeps them
   // steady from before the select falls until after the write ends
   // a dropped request (no lanes) leaves them unchanged
   always_ff @(posedge clock_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         mem_addr_out <= '0;
         mem_data_out <= '0;
      end else if ((state_q == asc_pkg::ASC_IDLE) && take_ok(req_in, req_lanes_in)) begin
         mem_addr_out <= req_addr_in;
         mem_data_out <= req_wdata_in;
      end
   end

   // ==========================================================
   // read capture at end of access wait, status outputs
   // capture falls on the last access cycle, when the lanes have been
   // selected and enabled for every wait cycle after the first and the flag is valid
   always_ff @(posedge clock_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rdata_out <= '0;
         rfix_out  <= 1'b0;
         done_out  <= 1'b0;
         busy_out  <= 1'b0;
      end else begin
         done_out <= 1'b0;
         // busy rises with the accepted request, falls after done
         busy_out <= (state_q != asc_pkg::ASC_IDLE) ||
                     take_ok(req_in, req_lanes_in);
         if (read_end(state_q, cnt_q)) begin
            // only selected lanes hold valid data; others read zero
            rdata_out <= mem_data_in & lane_mask(lanes_q);
            rfix_out  <= ecc_fix_flag_in;
            done_out  <= 1'b1;
         end else if (state_q == asc_pkg::ASC_WEND) begin
            // write complete one cycle after the strobe rose
            done_out <= 1'b1;
         end
      end
   end
endmodule // asc_ctrl

// >>> verif/asc_ctrl_monitor.sv
`timescale 1ns/100ps
// ==========
// pin order checks at the memory pins
module asc_ctrl_monitor #(
   parameter int ADDR_W = 20,
   parameter int DATA_W = 16
) (
   input wire logic              clock_in,
   input wire logic              resetn_in,
   input wire logic              first_select_n_out,
   input wire logic              second_select_out,
   input wire logic              output_enable_n_out,
   input wire logic              write_strobe_n_out,
   input wire logic              mem_data_oe_out,
   input wire logic [ADDR_W-1:0] mem_addr_out,
   input wire logic [DATA_W-1:0] mem_data_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!resetn_in);
   wire sel = !first_select_n_out && second_select_out; // memory selected
   a_read_strobe_high: assert property (sel && !output_enable_n_out |-> write_strobe_n_out)
      else $error("strobe low during read");
   a_addr_before_sel: assert property ($fell(first_select_n_out) |-> $stable(mem_addr_out))
      else $error("address moved as select fell");
   a_strobe_min_width: assert property ($fell(write_strobe_n_out) |->
      !write_strobe_n_out[*2])
      else $error("strobe low time too short");
   a_data_hold_end: assert property ($rose(write_strobe_n_out) |->
      sel && mem_data_oe_out && $stable(mem_data_out))
      else $error("write data released with strobe");
   a_no_drive_read: assert property (sel && !output_enable_n_out |-> !mem_data_oe_out)
      else $error("host drives lanes while memory drives");
   // main scenarios reached
   c_read: cover property (sel && !output_enable_n_out);
   c_write: cover property ($rose(write_strobe_n_out) && sel);
   c_drive: cover property (mem_data_oe_out && !write_strobe_n_out);
endmodule // asc_ctrl_monitor
bind asc_ctrl asc_ctrl_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) mon_u (.clock_in,
   .resetn_in, .first_select_n_out, .second_select_out, .output_enable_n_out,
   .write_strobe_n_out, .mem_data_oe_out, .mem_addr_out, .mem_data_out);

// >>> verif/asc_sram_model.sv
`timescale 1ns/100ps
// ==========
// behavioural memory, low 8 address bits only
module asc_sram_model (
   input  wire logic        clk_in,        // paces the float pattern
   input  wire logic [5:0]  pins_in,       // sel1_n sel2 oe_n we_n high_n low_n
   input  wire logic [19:0] addr_in,
   input  wire logic [15:0] host_data_in,
   input  wire logic        host_oe_in,
   input  wire logic [19:0] bad_addr_in,   // address whose reads raise the corrected-error flag
   output logic      [15:0] lanes_out,     // resolved data lanes
   output logic             ecc_fix_flag_out
);
   logic [15:0] mem [0:255];               // stored words, check bits implied
   logic        tgl = 1'b0;                // float pattern phase
   logic [15:0] wd;
   logic [1:0]  wl;
   logic [7:0]  wa;
   wire sel = !pins_in[5] && pins_in[4];
   wire [1:0] ln = ~pins_in[1:0] & 2'h3;
   wire wr = sel && !pins_in[2] && |ln;
   wire rd = sel && !pins_in[3] && pins_in[2] && |ln;
   wire [15:0] flt = 16'ha5a5 ^ {16{tgl}};
   wire [15:0] q = mem[addr_in[7:0]];
   initial for (int i = 0; i < 256; i++) mem[i] = 16'h0000;
   // released lanes never keep the last value
   always @(posedge clk_in) tgl <= ~tgl;
   // track what the write will store
   always @* if (wr) begin
      wa = addr_in[7:0];
      wl = ln;
      wd = lanes_out;
   end
   // first pin to leave its active level ends the write
   always @(negedge wr) begin
      if (wl[0]) mem[wa][7:0] = wd[7:0];
      if (wl[1]) mem[wa][15:8] = wd[15:8];
   end
   for (genvar i = 0; i < 2; i++) begin : g_lane
      wire dev = rd && ln[i];
      assign lanes_out[8*i+:8] = host_oe_in ? (dev ? 8'hxx : host_data_in[8*i+:8])
                                            : (dev ? q[8*i+:8] : flt[8*i+:8]);
   end
   assign ecc_fix_flag_out = rd ? (addr_in == bad_addr_in) : tgl;
endmodule // asc_sram_model

// >>> verif/tb_top.sv
`timescale 1ns/100ps
// ==========
// directed checks of the memory controller
module tb_top;
   logic        clock_in = 1'b0;
   logic        resetn_in = 1'b0;
   logic        req_in = 1'b0;
   logic        req_write_in = 1'b0;
   logic [1:0]  req_lanes_in = 2'h0;
   logic [19:0] req_addr_in = 20'h00000;
   logic [15:0] req_wdata_in = 16'h0000;
   wire  [15:0] lanes, rdata_out, mem_data_out;
   wire  [19:0] mem_addr_out;
   wire         fix, busy_out, done_out, rfix_out, mem_data_oe_out, first_select_n_out;
   wire         second_select_out, output_enable_n_out, write_strobe_n_out;
   wire         low_byte_sel_n_out, high_byte_sel_n_out;
   int          err_total = 0;
   int          tests_run = 0;
   asc_ctrl dut_u (.clock_in, .resetn_in, .req_in, .req_write_in, .req_lanes_in,
      .req_addr_in, .req_wdata_in, .mem_data_in(lanes), .ecc_fix_flag_in(fix), .busy_out,
      .done_out, .rdata_out, .rfix_out, .mem_addr_out, .mem_data_out, .mem_data_oe_out,
      .first_select_n_out, .second_select_out, .output_enable_n_out, .write_strobe_n_out,
      .low_byte_sel_n_out, .high_byte_sel_n_out);
   asc_sram_model sram_u (.clk_in(clock_in), .pins_in({first_select_n_out,
      second_select_out, output_enable_n_out, write_strobe_n_out, high_byte_sel_n_out,
      low_byte_sel_n_out}), .addr_in(mem_addr_out), .host_data_in(mem_data_out),
      .host_oe_in(mem_data_oe_out), .bad_addr_in(20'h00033), .lanes_out(lanes),
      .ecc_fix_flag_out(fix));
   initial forever #50 clock_in = ~clock_in;
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // one access: hold request until taken, then wait for done
   task automatic acc(input logic w, input logic [1:0] ln, input logic [19:0] a,
                      input logic [15:0] d);
      int n;
      logic [2:0] pv;
      @(negedge clock_in);
      req_in = 1'b1;
      req_write_in = w;
      req_lanes_in = ln;
      req_addr_in = a;
      req_wdata_in = d;
      for (n = 0; n < 20 && busy_out !== 1'b1; n++) @(negedge clock_in);
      if (busy_out !== 1'b1) begin
         err_total++;
         tally_and_finish();
      end
      req_in = 1'b0;
      for (n = 0; n < 20 && done_out !== 1'b1; n++) @(negedge clock_in);
      if (done_out !== 1'b1) begin
         err_total++;
         tally_and_finish();
      end
      // at done: strobe high; a write still holds select and data
      pv = {first_select_n_out, write_strobe_n_out, mem_data_oe_out};
      chk("end pins", {13'h0000, pv}, w ? 16'h0003 : 16'h0002);
   endtask
   task automatic t_full;
      acc(1'b1, 2'h3, 20'h00012, 16'h1234);
      acc(1'b0, 2'h3, 20'h00012, 16'h0000);
      chk("rdata", rdata_out, 16'h1234);
      chk("rfix", {15'h0000, rfix_out}, 16'h0000);
      $display("test full word done");
   endtask
   // byte lanes and back to back reads at two addresses
   task automatic t_bytes;
      acc(1'b1, 2'h1, 20'h00012, 16'habcd);
      acc(1'b1, 2'h2, 20'h00013, 16'h5678);
      acc(1'b0, 2'h3, 20'h00012, 16'h0000);
      chk("rdata", rdata_out, 16'h12cd);
      acc(1'b0, 2'h3, 20'h00013, 16'h0000);
      chk("rdata", rdata_out, 16'h5600);
      acc(1'b0, 2'h2, 20'h00012, 16'h0000);
      chk("rdata", rdata_out, 16'h1200);
      acc(1'b0, 2'h1, 20'h00012, 16'h0000);
      chk("rdata", rdata_out, 16'h00cd);
      $display("test byte lanes done");
   endtask
   // corrected word, then a clean one
   task automatic t_fix;
      acc(1'b1, 2'h3, 20'h00033, 16'h0f0f);
      acc(1'b0, 2'h3, 20'h00033, 16'h0000);
      chk("rdata", rdata_out, 16'h0f0f);
      chk("rfix", {15'h0000, rfix_out}, 16'h0001);
      acc(1'b0, 2'h3, 20'h00012, 16'h0000);
      chk("rfix", {15'h0000, rfix_out}, 16'h0000);
      $display("test correction flag done");
   endtask
   initial begin
      repeat (6) @(negedge clock_in);
      resetn_in = 1'b1;
      repeat (3) @(negedge clock_in);
      t_full();
      t_bytes();
      t_fix();
      tally_and_finish();
   end
endmodule // tb_top
